// file: iocl_group.sv
`timescale 1ns/1ps
module iocl_group
   import iocl_pkg::*;
#(
   parameter int N_CELLS = IOCL_ROW_CELLS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [IOCL_WB_AW-1:0] wb_adr_i,
   input wire logic [IOCL_WB_DW-1:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [IOCL_WB_DW-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [IOCL_DED_CLKS-1:0] dedicated_io_clock_i,
   input wire logic [N_CELLS-1:0] array_to_pin_data_i,
   input wire logic [N_CELLS-1:0] array_output_enable_i,
   input wire logic [N_CELLS-1:0] array_input_clock_enable_i,
   input wire logic [N_CELLS-1:0] array_output_clock_enable_i,
   input wire logic [N_CELLS-1:0] array_register_clock_i,
   input wire logic [N_CELLS-1:0] array_async_clear_i,
   input wire logic [N_CELLS-1:0] array_sync_clear_i,
   input wire logic [N_CELLS-1:0] pin_i,
   output logic [N_CELLS-1:0] pin_o,
   output logic [N_CELLS-1:0] pin_oe_n_o,
   output logic [N_CELLS-1:0] pin_input_value_a_o,
   output logic [N_CELLS-1:0] pin_input_value_b_o
);
   localparam int SRC_W = 1 << IOCL_SEL_W;

   // 7 sources plus the none code must fit the 3-bit selects
   if (N_CELLS < 1 || N_CELLS > IOCL_MAX_CELLS) begin : g_chk
      $error("iocl_group: N_CELLS out of range");
   end

   // Status and value fields sit one byte apart, so wider groups would overlap
   if (N_CELLS > IOCL_ST_IN_LSB - IOCL_ST_PIN_LSB) begin : g_fit
      $error("iocl_group: status fields too narrow");
   end

   iocl_cfg_t cfg_ff [N_CELLS];
   iocl_cfg_t nxt_cfg [N_CELLS];
   logic [IOCL_SEL_W-1:0] grp_src_ff;
   logic [IOCL_SEL_W-1:0] nxt_grp_src;

   logic ack_ff;
   logic nxt_ack;

   logic [IOCL_WB_DW-1:0] dat_ff;
   logic [IOCL_WB_DW-1:0] nxt_dat;

   logic [N_CELLS-1:0] q_in_w;
   logic [N_CELLS-1:0] q_out_w;
   logic [N_CELLS-1:0] q_oe_w;
   logic [N_CELLS-1:0] out_val_w;
   logic [N_CELLS-1:0] oe_val_w;
   logic [N_CELLS-1:0] in_b_val_w;
   logic [N_CELLS-1:0] in_a_en_w;
   logic grp_aclr_w;

   logic [N_CELLS-1:0] pin_o_ff;
   logic [N_CELLS-1:0] pin_oe_n_ff;
   logic [N_CELLS-1:0] in_a_ff;
   logic [N_CELLS-1:0] in_b_ff;

   logic [N_CELLS-1:0] nxt_pin_o;
   logic [N_CELLS-1:0] nxt_pin_oe_n;
   logic [N_CELLS-1:0] nxt_in_a;
   logic [N_CELLS-1:0] nxt_in_b;

   function automatic logic [IOCL_WB_DW-1:0] merge_bytes(
      input logic [IOCL_WB_DW-1:0] old_v,
      input logic [IOCL_WB_DW-1:0] new_v,
      input logic [3:0] sel
   );
      logic [IOCL_WB_DW-1:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Register bus: one access per request, ack one cycle after the strobe
   always_comb begin
      logic req;
      logic [IOCL_WB_DW-1:0] cur;
      logic [IOCL_WB_DW-1:0] upd;
      // Gating by the ack flop serves a held strobe every other cycle, never two cycles in a row
      req = wb_cyc_i && wb_stb_i && !ack_ff;
      cur = '0;
      upd = '0;
      nxt_ack = req;
      nxt_dat = dat_ff;
      nxt_grp_src = grp_src_ff;
      for (int i = 0; i < N_CELLS; i++) begin
         nxt_cfg[i] = cfg_ff[i];
      end
      if (req) begin
         nxt_dat = '0;
         for (int i = 0; i < N_CELLS; i++) begin
            if (wb_adr_i == IOCL_CELL_BASE + IOCL_WB_AW'(4 * i)) begin
               cur = IOCL_WB_DW'(cfg_ff[i]);
               upd = merge_bytes(cur, wb_dat_i, wb_sel_i);
               nxt_dat = cur;
               if (wb_we_i) begin
                  nxt_cfg[i] = iocl_cfg_t'(upd[IOCL_CFG_W-1:0]);
               end
            end
         end
         if (wb_adr_i == IOCL_GROUP_OFS) begin
            cur = IOCL_WB_DW'(grp_src_ff);
            upd = merge_bytes(cur, wb_dat_i, wb_sel_i);
            nxt_dat = cur;
            if (wb_we_i) begin
               nxt_grp_src = upd[IOCL_SEL_W-1:0];
            end
         end
         if (wb_adr_i == IOCL_STATUS_OFS) begin
            nxt_dat[IOCL_ST_PIN_LSB +: N_CELLS] = pin_i;
            nxt_dat[IOCL_ST_IN_LSB +: N_CELLS] = q_in_w;
            nxt_dat[IOCL_ST_OUT_LSB +: N_CELLS] = q_out_w;
            nxt_dat[IOCL_ST_OE_LSB +: N_CELLS] = q_oe_w;
         end
         if (wb_adr_i == IOCL_VALUE_OFS) begin
            nxt_dat[IOCL_ST_PIN_LSB +: N_CELLS] = in_a_ff;
            nxt_dat[IOCL_ST_IN_LSB +: N_CELLS] = in_b_ff;
            nxt_dat[IOCL_ST_OUT_LSB +: N_CELLS] = pin_o_ff;
            nxt_dat[IOCL_ST_OE_LSB +: N_CELLS] = pin_oe_n_ff;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= '0;
         grp_src_ff <= IOCL_GRP_RST;
         for (int i = 0; i < N_CELLS; i++) begin
            cfg_ff[i] <= IOCL_CFG_RST;
         end
      end else begin
         ack_ff <= nxt_ack;
         dat_ff <= nxt_dat;
         grp_src_ff <= nxt_grp_src;
         for (int i = 0; i < N_CELLS; i++) begin
            cfg_ff[i] <= nxt_cfg[i];
         end
      end
   end

   // One group-wide clear source; an out-of-range code means no clear
   assign grp_aclr_w = (grp_src_ff < IOCL_SEL_W'(N_CELLS)) ?
                       array_async_clear_i[grp_src_ff] : 1'b0;

   for (genvar i = 0; i < N_CELLS; i++) begin : g_cell
      logic [SRC_W-1:0] clk_src;
      logic tick_in;
      logic tick_out;
      logic ce_in;
      logic ce_out;
      logic oe_src;
      logic sclr;
      iocl_cfg_t c;

      assign c = cfg_ff[i];
      // Array clocks act as enable pulses on the single system clock
      assign clk_src = {1'b0, array_register_clock_i[i], dedicated_io_clock_i};

      iocl_sel #(.W(SRC_W), .SW(IOCL_SEL_W)) u_clk_in (
         .src_i(clk_src),
         .sel_i(c.clk_in_sel),
         .y_o(tick_in)
      );

      iocl_sel #(.W(SRC_W), .SW(IOCL_SEL_W)) u_clk_out (
         .src_i(clk_src),
         .sel_i(c.clk_out_sel),
         .y_o(tick_out)
      );

      assign ce_in = c.ce_in_use ? array_input_clock_enable_i[i] : 1'b1;
      assign ce_out = c.ce_out_use ? array_output_clock_enable_i[i] : 1'b1;
      assign oe_src = c.oe_use ? array_output_enable_i[i] : 1'b1;

      // An index at or above the cell count selects no sync clear
      assign sclr = (c.sclr_sel < IOCL_SEL_W'(N_CELLS)) ?
                    array_sync_clear_i[c.sclr_sel] : 1'b0;

      // Group-wide async clear, per-cell sync clear; one polarity per cell, so preset and clear never mix within a cell
      iocl_reg u_in (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .tick_i(tick_in),
         .ce_i(ce_in),
         .d_i(pin_i[i]),
         .sclr_i(sclr),
         .aclr_i(grp_aclr_w),
         .ign_sclr_i(c.sclr_ign[IOCL_R_IN]),
         .ign_aclr_i(c.aclr_ign[IOCL_R_IN]),
         .init_i(c.pwr_high),
         .q_o(q_in_w[i])
      );

      iocl_reg u_out (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .tick_i(tick_out),
         .ce_i(ce_out),
         .d_i(array_to_pin_data_i[i]),
         .sclr_i(sclr),
         .aclr_i(grp_aclr_w),
         .ign_sclr_i(c.sclr_ign[IOCL_R_OUT]),
         .ign_aclr_i(c.aclr_ign[IOCL_R_OUT]),
         .init_i(c.pwr_high),
         .q_o(q_out_w[i])
      );

      iocl_reg u_oe (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .tick_i(tick_out),
         .ce_i(ce_out),
         .d_i(oe_src),
         .sclr_i(sclr),
         .aclr_i(grp_aclr_w),
         .ign_sclr_i(c.sclr_ign[IOCL_R_OE]),
         .ign_aclr_i(c.aclr_ign[IOCL_R_OE]),
         .init_i(c.pwr_high),
         .q_o(q_oe_w[i])
      );

      // Bypassed data still passes the retiming flop, so it lags one cycle
      assign out_val_w[i] = c.out_reg ? q_out_w[i] : array_to_pin_data_i[i];

      assign oe_val_w[i] = (c.dir == IOCL_DIR_OUTPUT) ? 1'b1 :
                           (c.dir == IOCL_DIR_BIDIR) ?
                           (c.oe_reg ? q_oe_w[i] : oe_src) : 1'b0;
      // Input register, when used, takes path b; path a bypasses it and only passes the retiming flop
      assign in_b_val_w[i] = c.in_reg ? q_in_w[i] : pin_i[i];
      assign in_a_en_w[i] = (c.dir != IOCL_DIR_OUTPUT);

   end

   // Pin side is retimed once so every output leaves a flip-flop
   always_comb begin
      nxt_pin_o = out_val_w;
      nxt_pin_oe_n = ~oe_val_w;
      nxt_in_a = pin_i & in_a_en_w;
      nxt_in_b = in_b_val_w & in_a_en_w;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_o_ff <= '0;
         pin_oe_n_ff <= '1;
         in_a_ff <= '0;
         in_b_ff <= '0;
      end else begin
         pin_o_ff <= nxt_pin_o;
         pin_oe_n_ff <= nxt_pin_oe_n;
         in_a_ff <= nxt_in_a;
         in_b_ff <= nxt_in_b;
      end
   end

   // Row group: N_CELLS=5 gives 35 array signals; column: 4 gives 28
   assign pin_o = pin_o_ff;
   assign pin_oe_n_o = pin_oe_n_ff;
   assign pin_input_value_a_o = in_a_ff;
   assign pin_input_value_b_o = in_b_ff;
   assign wb_dat_o = dat_ff;
   assign wb_ack_o = ack_ff;
endmodule

// file: iocl_pkg.sv
package iocl_pkg;

   localparam int IOCL_ROW_CELLS = 5;
   localparam int IOCL_COL_CELLS = 4;
   localparam int IOCL_MAX_CELLS = 7;
   localparam int IOCL_DED_CLKS = 6;
   localparam int IOCL_SEL_W = 3;
   localparam int IOCL_WB_AW = 8;
   localparam int IOCL_WB_DW = 32;

   // Register byte offsets; cell i config sits at IOCL_CELL_BASE + 4*i
   localparam logic [IOCL_WB_AW-1:0] IOCL_CELL_BASE = 8'h00;
   localparam logic [IOCL_WB_AW-1:0] IOCL_GROUP_OFS = 8'h20;
   localparam logic [IOCL_WB_AW-1:0] IOCL_STATUS_OFS = 8'h24;
   localparam logic [IOCL_WB_AW-1:0] IOCL_VALUE_OFS = 8'h28;

   // Status field positions
   localparam int IOCL_ST_PIN_LSB = 0;
   localparam int IOCL_ST_IN_LSB = 8;
   localparam int IOCL_ST_OUT_LSB = 16;
   localparam int IOCL_ST_OE_LSB = 24;

   // Clock source codes: 0..5 dedicated clocks, then own array clock, then none
   localparam logic [IOCL_SEL_W-1:0] IOCL_CLK_ARRAY = 3'h6;
   localparam logic [IOCL_SEL_W-1:0] IOCL_SRC_NONE = 3'h7;

   typedef enum logic [1:0] {
      IOCL_DIR_INPUT,
      IOCL_DIR_OUTPUT,
      IOCL_DIR_BIDIR,
      IOCL_DIR_RSVD
   } iocl_dir_t;

   // Index of each register within a cell for the ignore masks
   localparam int IOCL_R_IN = 0;
   localparam int IOCL_R_OUT = 1;
   localparam int IOCL_R_OE = 2;

   typedef struct packed {
      logic [IOCL_SEL_W-1:0] sclr_sel;
      logic [2:0] sclr_ign;
      logic [2:0] aclr_ign;
      logic pwr_high;
      logic oe_use;
      logic ce_out_use;
      logic ce_in_use;
      logic [IOCL_SEL_W-1:0] clk_out_sel;
      logic [IOCL_SEL_W-1:0] clk_in_sel;
      logic oe_reg;
      logic out_reg;
      logic in_reg;
      iocl_dir_t dir;
   } iocl_cfg_t;

   localparam int IOCL_CFG_W = $bits(iocl_cfg_t);

   localparam iocl_cfg_t IOCL_CFG_RST = '{
      sclr_sel: IOCL_SRC_NONE,
      sclr_ign: 3'h0,
      aclr_ign: 3'h0,
      pwr_high: 1'b0,
      oe_use: 1'b0,
      ce_out_use: 1'b0,
      ce_in_use: 1'b0,
      clk_out_sel: IOCL_SRC_NONE,
      clk_in_sel: IOCL_SRC_NONE,
      oe_reg: 1'b0,
      out_reg: 1'b0,
      in_reg: 1'b0,
      dir: IOCL_DIR_INPUT
   };

   localparam logic [IOCL_SEL_W-1:0] IOCL_GRP_RST = IOCL_SRC_NONE;

endpackage

// file: iocl_sel.sv
`timescale 1ns/1ps
module iocl_sel #(
   parameter int W = 8,
   parameter int SW = 3
) (
   input wire logic [W-1:0] src_i,
   input wire logic [SW-1:0] sel_i,
   output logic y_o
);
   if (W > (1 << SW)) begin : g_chk
      $error("iocl_sel: select too narrow");
   end

   always_comb begin
      y_o = src_i[sel_i];
   end
endmodule

// file: iocl_reg.sv
`timescale 1ns/1ps
module iocl_reg (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic tick_i,
   input wire logic ce_i,
   input wire logic d_i,
   input wire logic sclr_i,
   input wire logic aclr_i,
   input wire logic ign_sclr_i,
   input wire logic ign_aclr_i,
   input wire logic init_i,
   output logic q_o
);
   logic q_ff;
   logic nxt_q;

   // Clear forces the power-up level: low means clear, high means preset
   always_comb begin
      nxt_q = q_ff;
      if (aclr_i && !ign_aclr_i) begin
         nxt_q = init_i;
      end else if (tick_i && ce_i) begin
         nxt_q = (sclr_i && !ign_sclr_i) ? init_i : d_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_ff <= init_i;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign q_o = q_ff;
endmodule

// file: iocl_pin_model.sv
`timescale 1ns/1ps
module iocl_pin_model #(
   parameter int N = 5
) (
   input wire logic clk_i,
   input wire logic [N-1:0] drv_i,
   input wire logic [N-1:0] drv_oe_n_i,
   input wire logic [N-1:0] ext_val_i,
   input wire logic [N-1:0] ext_en_i,
   output logic [N-1:0] level_o
);
   logic [N-1:0] flt_ff = '0;
   // No pull on the pad, so a floating pin flips each cycle and a stale value cannot pass
   always_ff @(posedge clk_i) begin
      flt_ff <= ~flt_ff;
   end
   always_comb begin
      for (int i = 0; i < N; i++) begin
         level_o[i] = !drv_oe_n_i[i] ? drv_i[i] : (ext_en_i[i] ? ext_val_i[i] : flt_ff[i]);
      end
   end
endmodule

// file: iocl_group_checker.sv
`timescale 1ns/1ps
module iocl_group_checker
   import iocl_pkg::*;
#(
   parameter int N_CELLS = IOCL_ROW_CELLS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [IOCL_WB_AW-1:0] wb_adr_i,
   input wire logic [IOCL_WB_DW-1:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [IOCL_DED_CLKS-1:0] dedicated_io_clock_i,
   input wire logic [N_CELLS-1:0] array_to_pin_data_i,
   input wire logic [N_CELLS-1:0] array_input_clock_enable_i,
   input wire logic [N_CELLS-1:0] array_output_clock_enable_i,
   input wire logic [N_CELLS-1:0] array_register_clock_i,
   input wire logic [N_CELLS-1:0] array_async_clear_i,
   input wire logic [N_CELLS-1:0] pin_i,
   input wire logic [N_CELLS-1:0] pin_o,
   input wire logic [N_CELLS-1:0] pin_oe_n_o,
   input wire logic [N_CELLS-1:0] pin_input_value_a_o,
   input wire logic [N_CELLS-1:0] pin_input_value_b_o
);
   // Shadow of cell 0 and the group source; only full-word writes are tracked
   iocl_cfg_t cfg_ff, nxt_cfg;
   logic [2:0] grp_ff, nxt_grp;
   logic wr, aclr_on, upd_out, upd_in, hold_out;
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i == 4'hF;
   assign aclr_on = grp_ff < N_CELLS && array_async_clear_i[grp_ff];
   assign upd_out = cfg_ff.out_reg && cfg_ff.dir != IOCL_DIR_INPUT && cfg_ff.clk_out_sel == 3'h0
      && dedicated_io_clock_i[0] && (!cfg_ff.ce_out_use || array_output_clock_enable_i[0])
      && cfg_ff.sclr_sel == IOCL_SRC_NONE && !aclr_on;
   assign upd_in = cfg_ff.in_reg && cfg_ff.dir != IOCL_DIR_OUTPUT && array_register_clock_i[0]
      && cfg_ff.clk_in_sel == IOCL_CLK_ARRAY && (!cfg_ff.ce_in_use || array_input_clock_enable_i[0])
      && cfg_ff.sclr_sel == IOCL_SRC_NONE && !aclr_on;
   assign hold_out = cfg_ff.out_reg && !aclr_on && (cfg_ff.clk_out_sel == IOCL_SRC_NONE
      || (cfg_ff.ce_out_use && !array_output_clock_enable_i[0]));
   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_grp = grp_ff;
      if (wr && wb_adr_i == IOCL_CELL_BASE) nxt_cfg = iocl_cfg_t'(wb_dat_i[IOCL_CFG_W-1:0]);
      if (wr && wb_adr_i == IOCL_GROUP_OFS) nxt_grp = wb_dat_i[2:0];
      if (rst_i) begin
         nxt_cfg = IOCL_CFG_RST;
         nxt_grp = IOCL_GRP_RST;
      end
   end
   always_ff @(posedge clk_i) begin
      cfg_ff <= nxt_cfg;
      grp_ff <= nxt_grp;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked");
   a_rst_release: assert property (disable iff (1'b0) rst_i |=> &pin_oe_n_o && !wb_ack_o)
      else $error("reset state wrong");
   a_path_a: assert property (!$past(rst_i) |-> (pin_input_value_a_o & ~$past(pin_i)) == '0)
      else $error("input path shows value not on pin");
   a_input_only: assert property (cfg_ff.dir == IOCL_DIR_INPUT |=> pin_oe_n_o[0])
      else $error("input-only cell drives pin");
   a_oe_const: assert property (cfg_ff.dir == IOCL_DIR_OUTPUT && !cfg_ff.oe_use && !cfg_ff.oe_reg
      |=> !pin_oe_n_o[0]) else $error("output cell not driving");
   a_out_tick: assert property (upd_out ##1 cfg_ff.out_reg
      |=> pin_o[0] == $past(array_to_pin_data_i[0], 2)) else $error("output reg missed tick");
   a_out_hold: assert property (hold_out [*2] |=> $stable(pin_o[0]))
      else $error("output reg changed without enable");
   a_in_reg: assert property (upd_in ##1 cfg_ff.in_reg
      |=> pin_input_value_b_o[0] == $past(pin_i[0], 2)) else $error("input reg missed tick");
   a_aclr_force: assert property (aclr_on && cfg_ff.out_reg && !cfg_ff.aclr_ign[IOCL_R_OUT]
      ##1 cfg_ff.out_reg |=> pin_o[0] == $past(cfg_ff.pwr_high, 2)) else $error("clear not forced");
   c_out_tick: cover property (upd_out);
   c_in_tick: cover property (upd_in);
   c_preset: cover property (aclr_on && cfg_ff.pwr_high);
endmodule
bind iocl_group iocl_group_checker #(.N_CELLS(N_CELLS)) u_chk (.clk_i, .rst_i, .wb_adr_i,
   .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .dedicated_io_clock_i,
   .array_to_pin_data_i, .array_input_clock_enable_i, .array_output_clock_enable_i,
   .array_register_clock_i, .array_async_clear_i, .pin_i, .pin_o, .pin_oe_n_o,
   .pin_input_value_a_o, .pin_input_value_b_o);

// file: iocl_testbench.sv
`timescale 1ns/1ps
module testbench;
   import iocl_pkg::*;
   localparam int N = IOCL_ROW_CELLS;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, dat_o;
   logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack;
   logic [5:0] ded = 6'h00;
   logic [N-1:0] dat = '0, oe = '0, cei = '0, ceo = '0, rclk = '0, aclr = '0, sclr = '0;
   logic [N-1:0] ext_val = '0, ext_en = '0, pin_i, pin_o, oe_n, va, vb;
   int err_count = 0, n_checks = 0, cyc_n = 0;
   iocl_cfg_t c;
   always #20 clk_i = ~clk_i;
   iocl_group #(.N_CELLS(N)) uut (.clk_i, .rst_i, .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .dedicated_io_clock_i(ded), .array_to_pin_data_i(dat),
      .array_output_enable_i(oe), .array_input_clock_enable_i(cei),
      .array_output_clock_enable_i(ceo), .array_register_clock_i(rclk),
      .array_async_clear_i(aclr), .array_sync_clear_i(sclr), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe_n_o(oe_n), .pin_input_value_a_o(va), .pin_input_value_b_o(vb));
   iocl_pin_model #(.N(N)) pm (.clk_i, .drv_i(pin_o), .drv_oe_n_i(oe_n), .ext_val_i(ext_val),
      .ext_en_i(ext_en), .level_o(pin_i));
   task automatic stop_test();
      if (err_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Ack is sampled before the edge's own updates land, as a master would see it
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wcfg();
      bus(1'b1, IOCL_CELL_BASE, 32'(c));
   endtask
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n > 4000) begin
         err_count++;
         stop_test();
      end
   end
   initial begin
      tk(6);
      rst_i <= 1'b0;
      bus(1'b0, IOCL_CELL_BASE, 32'h0);
      chk(rdat, 32'(IOCL_CFG_RST));
      chk(32'(oe_n), 32'({N{1'b1}}));
      bus(1'b1, 8'h40, 32'hFFFFFFFF);
      bus(1'b0, 8'h40, 32'h0);
      chk(rdat, 32'h0);
      c = IOCL_CFG_RST;
      c.dir = IOCL_DIR_OUTPUT;
      wcfg();
      dat <= 5'h01;
      tk(3);
      chk(32'({pin_o[0], oe_n[0], va[0]}), 32'h4);
      c.dir = IOCL_DIR_BIDIR;
      c.out_reg = 1'b1;
      c.oe_reg = 1'b1;
      c.oe_use = 1'b1;
      c.clk_out_sel = 3'h0;
      c.ce_out_use = 1'b1;
      wcfg();
      oe <= 5'h01;
      ded <= 6'h01;
      tk(1);
      ded <= 6'h00;
      tk(3);
      chk(32'({pin_o[0], oe_n[0]}), 32'h1);
      ceo <= 5'h01;
      ded <= 6'h01;
      tk(1);
      dat <= 5'h00;
      tk(1);
      ded <= 6'h00;
      tk(1);
      chk(32'({pin_o[0], oe_n[0]}), 32'h2);
      tk(1);
      chk(32'(pin_o[0]), 32'h0);
      c = IOCL_CFG_RST;
      c.in_reg = 1'b1;
      c.clk_in_sel = IOCL_CLK_ARRAY;
      c.ce_in_use = 1'b1;
      wcfg();
      ext_en <= '1;
      ext_val <= '1;
      rclk <= 5'h01;
      tk(1);
      rclk <= 5'h00;
      tk(3);
      chk(32'({va[0], vb[0]}), 32'h2);
      cei <= 5'h01;
      rclk <= 5'h01;
      tk(1);
      rclk <= 5'h00;
      ext_val <= '0;
      tk(3);
      chk(32'({va[0], vb[0]}), 32'h1);
      ext_en <= '0;
      c = IOCL_CFG_RST;
      c.dir = IOCL_DIR_OUTPUT;
      c.out_reg = 1'b1;
      c.pwr_high = 1'b1;
      wcfg();
      bus(1'b1, IOCL_GROUP_OFS, 32'h2);
      // Preset, then a line that is not the group source, then clear, then ignored preset
      for (int k = 0; k < 4; k++) begin
         c.pwr_high = k != 2;
         c.aclr_ign[IOCL_R_OUT] = k == 3;
         wcfg();
         aclr <= (k == 1) ? 5'h02 : 5'h04;
         tk(1);
         aclr <= 5'h00;
         tk(3);
         chk(32'(pin_o[0]), (k < 2) ? 32'h1 : 32'h0);
      end
      c = IOCL_CFG_RST;
      c.dir = IOCL_DIR_OUTPUT;
      c.out_reg = 1'b1;
      c.clk_out_sel = 3'h0;
      c.sclr_sel = 3'h3;
      c.pwr_high = 1'b1;
      wcfg();
      sclr <= 5'h08;
      ded <= 6'h01;
      tk(1);
      ded <= 6'h00;
      tk(3);
      chk(32'(pin_o[0]), 32'h1);
      stop_test();
   end
endmodule
